/* common/ccc_pkg.sv */
// shared constants for the capture/compare channel control block
package ccc_pkg;
    // register addresses in the special function register space
    localparam logic [7:0] CCC_MODE2_ADDR  = 8'hdc;
    localparam logic [7:0] CCC_CPL1_ADDR   = 8'he9;
    localparam logic [7:0] CCC_CPH1_ADDR   = 8'hea;
    // reset values
    localparam logic [7:0] CCC_MODE_RST    = 8'h00;
    localparam logic [7:0] CCC_BYTE_RST    = 8'h00;
    // mode register field positions
    localparam int CCC_B_WIDE = 7;
    localparam int CCC_B_CMPEN = 6;
    localparam int CCC_B_RISE = 5;
    localparam int CCC_B_FALL = 4;
    localparam int CCC_B_MATCH  = 3;
    localparam int CCC_B_TOGGLE = 2;
    localparam int CCC_B_PWM  = 1;
    localparam int CCC_B_IRQ  = 0;
    // output function of the channel
    typedef enum logic [2:0] {
        CCC_FN_IDLE,
        CCC_FN_TOGGLE,
        CCC_FN_PWM8,
        CCC_FN_WIDE_PWM_SELECT,
        CCC_FN_FREQ
    } ccc_fn_t;
endpackage : ccc_pkg

/* rtl/ccc_channel_ctl.sv */
`timescale 1ns/10ps
// Summary of operation
// - With PWM on, width select 0 gives 8 to 11-bit PWM and 1 gives 16-bit PWM.
// - The comparator works only while compare enable, bit 6, is set.
// - Rise capture enable, bit 5, captures the counter on a rising input edge.
// - Fall capture enable, bit 4, captures the counter on a falling input edge.
// - Match flag enable, bit 3, sets the channel event flag on a counter match.
// - Toggle enable, bit 2, inverts the output pin on every counter match.
// - PWM enable, bit 1, drives a pulse-width modulated output on the pin.
// - PWM and toggle together select frequency output mode.
// - The event flag raises an interrupt only while interrupt enable, bit 0, is set.
// - The low-byte register reads and writes bits 7:0 of channel 1's value.
// - For 9 to 11-bit PWM the reload select steers the low-byte address to the reload byte.
// - A write to channel 1's low byte clears its compare enable.
// - A write to channel 1's high byte sets its compare enable.
// - Center align picks edge (0) or center (1) output, only in PWM modes.
module ccc_channel_ctl
    import ccc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // special function register port
    input  wire logic [7:0]       sfr_addr,
    input  wire logic             sfr_wr,
    input  wire logic             sfr_rd,
    input  wire logic [7:0]       sfr_wdata,
    output logic      [7:0]       sfr_rdata,
    // counter array context
    input  wire logic [CNT_W-1:0] counter,
    input  wire logic             reload_access_select,
    input  wire logic             chan2_center_align,
    input  wire logic [1:0]       pwm_narrow_bits,
    input  wire logic             chan2_flag_clear,
    input  wire logic             chan1_compare_enable_in,
    // channel 2 value and flag
    input  wire logic [CNT_W-1:0] chan2_compare,
    output logic      [CNT_W-1:0] chan2_capture,
    output logic                  chan2_capture_strobe,
    output logic                  chan2_event_flag,
    output logic                  chan2_irq,
    // channel 1 side effects
    output logic                  chan1_compare_enable_set,
    output logic                  chan1_compare_enable_clr,
    output logic      [7:0]       chan1_compare_high,
    output logic      [7:0]       chan1_reload_low,
    output logic      [7:0]       chan1_reload_high,
    output logic      [7:0]       chan1_compare_low,
    // pin
    input  wire logic             chan2_pin_in,
    output logic                  chan2_output_pin
);
    logic [7:0]       mode_r;
    logic [7:0]       cpl1_r;
    logic [7:0]       cph1_r;
    logic [7:0]       arl1_r;
    logic [7:0]       arh1_r;
    logic [CNT_W-1:0] cap_r;
    logic             cap_stb_r;
    logic             flag_r;
    logic             out_r;
    logic             pin_rise;
    logic             pin_fall;

    // counter width for a given PWM mode: 8..11 bits from config, or full width
    function automatic logic [CNT_W-1:0] pwm_mask(input logic wide, input logic [1:0] nb);
        logic [CNT_W-1:0] m;
        m = '0;
        if (wide) begin
            m = '1;
        end else begin
            m = CNT_W'((16'h00ff << nb) | {8'h00, 8'hff} | (16'h0001 << (5'd8 + 5'(nb))) - 16'h0001);
        end
        return m;
    endfunction : pwm_mask

    ccc_edge_sync u_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .pin_in (chan2_pin_in),
        .level  (),
        .rise   (pin_rise),
        .fall   (pin_fall)
    );

    // field decode
    wire       cmp_en   = mode_r[CCC_B_CMPEN];
    wire       pwm_on   = mode_r[CCC_B_PWM];
    wire       tog_on   = mode_r[CCC_B_TOGGLE];
    wire       wide     = mode_r[CCC_B_WIDE];
    wire       narrow   = pwm_on && !wide;
    wire       use_arl  = narrow && reload_access_select && (pwm_narrow_bits != 2'b00);
    wire [CNT_W-1:0] msk  = pwm_mask(wide, pwm_narrow_bits);
    wire [CNT_W-1:0] cnt_m = counter & msk;
    wire [CNT_W-1:0] cmp_m = chan2_compare & msk;
    wire       match    = cmp_en && (pwm_on ? (cnt_m == cmp_m) : (counter == chan2_compare));
    wire       top      = (cnt_m == msk);
    wire       wr_mode  = sfr_wr && (sfr_addr == CCC_MODE2_ADDR);
    wire       wr_cpl1  = sfr_wr && (sfr_addr == CCC_CPL1_ADDR);
    wire       wr_cph1  = sfr_wr && (sfr_addr == CCC_CPH1_ADDR);
    wire       cap_ev   = (mode_r[CCC_B_RISE] && pin_rise) || (mode_r[CCC_B_FALL] && pin_fall);
    wire       flag_set = (mode_r[CCC_B_MATCH] && match) || cap_ev;
    ccc_fn_t   fn;

    // output function selection; both bits together win as frequency output
    always_comb begin
        if (pwm_on && tog_on) begin
            fn = CCC_FN_FREQ;
        end else if (pwm_on) begin
            fn = wide ? CCC_FN_WIDE_PWM_SELECT : CCC_FN_PWM8;
        end else if (tog_on) begin
            fn = CCC_FN_TOGGLE;
        end else begin
            fn = CCC_FN_IDLE;
        end
    end

    // register writes; low byte clears and high byte sets channel 1 compare enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_r <= CCC_MODE_RST;
            cpl1_r <= CCC_BYTE_RST;
            cph1_r <= CCC_BYTE_RST;
            arl1_r <= CCC_BYTE_RST;
            arh1_r <= CCC_BYTE_RST;
        end else if (ce) begin
            if (wr_mode) begin
                mode_r <= sfr_wdata;
            end
            if (wr_cpl1 && use_arl) begin
                arl1_r <= sfr_wdata;
            end else if (wr_cpl1) begin
                cpl1_r <= sfr_wdata;
            end
            if (wr_cph1 && use_arl) begin
                arh1_r <= sfr_wdata;
            end else if (wr_cph1) begin
                cph1_r <= sfr_wdata;
            end
        end
    end

    // side-effect strobes toward channel 1's mode register
    assign chan1_compare_enable_clr = ce && wr_cpl1;
    assign chan1_compare_enable_set = ce && wr_cph1;

    // capture path and event flag; a new event wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cap_r     <= '0;
            cap_stb_r <= 1'b0;
            flag_r    <= 1'b0;
        end else if (ce) begin
            cap_stb_r <= cap_ev;
            if (cap_ev) begin
                cap_r <= counter;
            end
            if (flag_set) begin
                flag_r <= 1'b1;
            end else if (chan2_flag_clear) begin
                flag_r <= 1'b0;
            end
        end
    end

    // output pin: toggle on match, or PWM edge/center aligned
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_r <= 1'b0;
        end else if (ce) begin
            unique case (fn)
                CCC_FN_TOGGLE, CCC_FN_FREQ: begin
                    if (match) begin
                        out_r <= ~out_r;
                    end
                end
                CCC_FN_PWM8, CCC_FN_WIDE_PWM_SELECT: begin
                    if (!cmp_en) begin
                        out_r <= 1'b0; // comparator off holds output low
                    end else if (chan2_center_align) begin
                        // center aligned: a pure level compare, so an up/down counter
                        // gives a pulse centred on its turn-around
                        out_r <= (cnt_m >= cmp_m);
                    end else begin
                        // edge aligned: high from match until rollover
                        if (match) begin
                            out_r <= 1'b1;
                        end else if (top) begin
                            out_r <= 1'b0;
                        end
                    end
                end
                CCC_FN_IDLE: begin
                    out_r <= out_r;
                end
            endcase
        end
    end

    // read mux; high byte reads the reload value when selected
    always_comb begin
        sfr_rdata = 8'h00;
        if (sfr_rd) begin
            if (sfr_addr == CCC_MODE2_ADDR) begin
                sfr_rdata = mode_r;
            end else if (sfr_addr == CCC_CPL1_ADDR) begin
                sfr_rdata = use_arl ? arl1_r : cpl1_r;
            end else if (sfr_addr == CCC_CPH1_ADDR) begin
                sfr_rdata = use_arl ? arh1_r : cph1_r;
            end
        end
    end

    assign chan2_capture        = cap_r;
    assign chan2_capture_strobe = cap_stb_r;
    assign chan2_event_flag     = flag_r;
    assign chan2_irq            = flag_r && mode_r[CCC_B_IRQ];
    assign chan2_output_pin     = out_r;
    assign chan1_compare_low    = cpl1_r;
    assign chan1_compare_high   = cph1_r;
    assign chan1_reload_low     = arl1_r;
    assign chan1_reload_high    = arh1_r;
endmodule : ccc_channel_ctl

/* rtl/ccc_edge_sync.sv */
`timescale 1ns/10ps
// three-stage pin synchroniser with rise and fall event pulses
module ccc_edge_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // pin and events
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;

    // first stage feeds only the second; level changes once stages 2 and 3 agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            s3_r  <= 1'b0;
            lvl_r <= 1'b0;
        end else if (ce) begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                lvl_r <= s3_r;
            end
        end
    end

    // event pulses only while enabled
    assign level = lvl_r;
    assign rise  = ce && (s2_r == s3_r) && s3_r && !lvl_r;
    assign fall  = ce && (s2_r == s3_r) && !s3_r && lvl_r;
endmodule : ccc_edge_sync

/* sim/ccc_channel_ctl_asserts.sv */
`timescale 1ns/10ps
// port assertions for the channel control block
module ccc_channel_ctl_asserts
    import ccc_pkg::*;
(
    // watched ports
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       ce,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       reload_access_select,
    input wire logic       chan2_capture_strobe,
    input wire logic       chan2_event_flag,
    input wire logic       chan2_irq,
    input wire logic       chan1_compare_enable_set,
    input wire logic       chan1_compare_enable_clr,
    input wire logic [7:0] chan1_compare_low
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // decoded accepted writes and reads
    wire wr_lo = ce && sfr_wr && sfr_addr == CCC_CPL1_ADDR;
    wire wr_hi = ce && sfr_wr && sfr_addr == CCC_CPH1_ADDR;
    wire wr_md = ce && sfr_wr && sfr_addr == CCC_MODE2_ADDR;
    wire rd_lo = sfr_rd && sfr_addr == CCC_CPL1_ADDR && !reload_access_select;
    wire mapped = sfr_addr inside {CCC_MODE2_ADDR, CCC_CPL1_ADDR, CCC_CPH1_ADDR};

    a_low_clears_cmpen: assert property (wr_lo == chan1_compare_enable_clr)
        else $error("enable clear strobe wrong");
    a_high_sets_cmpen: assert property (wr_hi == chan1_compare_enable_set)
        else $error("enable set strobe wrong");
    a_irq_needs_flag: assert property (chan2_irq |-> chan2_event_flag)
        else $error("irq without flag");
    a_low_read_value: assert property (rd_lo |-> sfr_rdata == chan1_compare_low)
        else $error("low byte read wrong");
    a_low_write_lands: assert property (wr_lo && !reload_access_select
        |=> chan1_compare_low == $past(sfr_wdata)) else $error("low byte write lost");
    a_mode_read_back: assert property (sfr_rd && sfr_addr == CCC_MODE2_ADDR
        && $past(wr_md) |-> sfr_rdata == $past(sfr_wdata)) else $error("mode readback");
    a_strobe_sets_flag: assert property (chan2_capture_strobe |-> chan2_event_flag)
        else $error("capture without flag");
    a_unmapped_zero: assert property (sfr_rd && !mapped |-> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : ccc_channel_ctl_asserts

bind ccc_channel_ctl ccc_channel_ctl_asserts u_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .reload_access_select(reload_access_select),
    .chan2_capture_strobe(chan2_capture_strobe), .chan2_event_flag(chan2_event_flag),
    .chan2_irq(chan2_irq), .chan1_compare_enable_set(chan1_compare_enable_set),
    .chan1_compare_enable_clr(chan1_compare_enable_clr),
    .chan1_compare_low(chan1_compare_low));

/* sim/ccc_pin_model.sv */
`timescale 1ns/10ps
// far-side source driving the channel pin
module ccc_pin_model #(
    parameter int DLY = 1
) (
    // clock and requested level
    input  wire logic clk,
    input  wire logic want,
    // pin
    output logic      pin
);
    // moves only after an edge, DLY cycles late, so slow sources are modelled too
    logic [7:0] hist = 8'h00;
    assign pin = hist[DLY-1];
    always @(posedge clk) begin
        hist <= {hist[6:0], want};
    end
endmodule : ccc_pin_model

/* sim/testbench.sv */
`timescale 1ns/10ps
// self-checking bench for the channel control block
module testbench;
    import ccc_pkg::*;
    logic clk = 0, rst_n = 0, ce = 1, wr = 0, rd = 0, ras = 0, fclr = 0, want = 0, got;
    logic [7:0]  addr = 0, wd = 0, d, m, rdata, c1h, rl, rh, c1l;
    logic [1:0]  nb = 0;
    logic [15:0] cnt = 0, cmp = 0, v, cap;
    logic [31:0] seed = 29;
    logic        stb, flag, irq, eset, eclr, pout, pin, p;
    logic        ca = 0;
    int          n_errors = 0, cmp_count = 0, cyc = 0;
    logic [7:0]  modes [5] = '{8'h49, 8'h48, 8'h08, 8'h44, 8'h4d};
    logic [7:0]  cmodes [3] = '{8'h20, 8'h10, 8'h10};

    ccc_channel_ctl uut (.clk(clk), .rst_n(rst_n), .ce(ce), .sfr_addr(addr), .sfr_wr(wr),
        .sfr_rd(rd), .sfr_wdata(wd), .sfr_rdata(rdata), .counter(cnt),
        .reload_access_select(ras), .chan2_center_align(ca), .pwm_narrow_bits(nb),
        .chan2_flag_clear(fclr), .chan1_compare_enable_in(1'b0), .chan2_compare(cmp),
        .chan2_capture(cap), .chan2_capture_strobe(stb), .chan2_event_flag(flag),
        .chan2_irq(irq), .chan1_compare_enable_set(eset), .chan1_compare_enable_clr(eclr),
        .chan1_compare_high(c1h), .chan1_reload_low(rl), .chan1_reload_high(rh),
        .chan1_compare_low(c1l), .chan2_pin_in(pin), .chan2_output_pin(pout));
    ccc_pin_model #(.DLY(2)) u_pin (.clk(clk), .want(want), .pin(pin));

    // clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            conclude();
        end
    end

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : check

    // one write cycle; strobes are combinational so they are seen in the write cycle
    task automatic write(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk) {wr, addr, wd} <= {1'b1, a, x};
        #1 check(eclr, a == CCC_CPL1_ADDR, "clr");
        check(eset, a == CCC_CPH1_ADDR, "set");
        @(posedge clk) wr <= 0;
        #1;
    endtask : write

    task automatic read(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk) {rd, addr} <= {1'b1, a};
        #1 check(rdata, x, "rdata");
        @(posedge clk) rd <= 0;
    endtask : read

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1;
        read(CCC_MODE2_ADDR, CCC_MODE_RST);
        read(CCC_CPL1_ADDR, CCC_BYTE_RST);
        read(8'h5a, 8'h00);
        // random byte traffic, software writes low before high
        for (int i = 0; i < 8; i++) begin
            d = rnd();
            write(CCC_CPL1_ADDR, d);
            read(CCC_CPL1_ADDR, d);
            write(CCC_CPH1_ADDR, ~d);
            check(c1h, {8'h00, ~d}, "high");
            write(CCC_MODE2_ADDR, d ^ 8'h5c);
            read(CCC_MODE2_ADDR, d ^ 8'h5c);
        end
        // clock enable low: a write is neither taken nor signalled
        d = c1l;
        @(posedge clk) {ce, wr, addr, wd} <= {1'b0, 1'b1, CCC_CPL1_ADDR, ~d};
        #1 check(eclr, 1'b0, "frozen clr");
        @(posedge clk) {ce, wr} <= 2'b10;
        #1 check(c1l, d, "frozen low");
        // read in the cycle right after a mode write
        @(posedge clk) {wr, addr, wd} <= {1'b1, CCC_MODE2_ADDR, 8'h5a};
        @(posedge clk) {wr, rd} <= 2'b01;
        #1 check(rdata, 8'h5a, "mode at once");
        @(posedge clk) rd <= 0;
        // counter match in each mode: flag, mask, no-compare, toggle
        foreach (modes[k]) begin
            m = modes[k];
            v = {rnd(), rnd()};
            write(CCC_MODE2_ADDR, m);
            @(posedge clk) {fclr, cmp, cnt} <= {1'b1, v, v + 16'h1};
            @(posedge clk) {fclr, cnt} <= {1'b0, v};
            #1 p = pout;
            @(posedge clk) cnt <= v + 16'h1;
            #1 check(flag, m[6] & m[3], "flag");
            check(irq, m[6] & m[3] & m[0], "irq");
            check(pout, p ^ (m[6] & m[2]), "pin");
        end
        // captures: rising, falling, and a rising edge with fall-only capture
        foreach (cmodes[k]) begin
            v = {rnd(), rnd()};
            write(CCC_MODE2_ADDR, cmodes[k]);
            @(posedge clk) {cnt, want} <= {v, ~want};
            got = 0;
            repeat (12) begin
                @(posedge clk) #1 got = got | (stb === 1'b1);
            end
            check(got, k < 2, "strobe");
            if (k < 2) check(cap, v, "capture");
        end
        // narrow PWM with reload select steers the low byte away from the compare value
        write(CCC_MODE2_ADDR, 8'h42);
        @(posedge clk) {ras, nb} <= {1'b1, 2'h1};
        d = rnd();
        m = c1l;
        write(CCC_CPL1_ADDR, d);
        check(rl, d, "reload");
        check(c1l, m, "low");
        read(CCC_CPL1_ADDR, d);
        write(CCC_CPH1_ADDR, ~d);
        check(rh, {8'h00, ~d}, "reload high");
        write(CCC_MODE2_ADDR, 8'hc2);
        write(CCC_CPL1_ADDR, ~d);
        check(c1l, {8'h00, ~d}, "low16");
        // edge-aligned 16-bit PWM: high from match until the counter tops out
        v = {rnd(), rnd()} & 16'h7fff;
        @(posedge clk) {cmp, cnt} <= {v, v};
        @(posedge clk) cnt <= 16'hffff;
        #1 check(pout, 1'b1, "pwm rise");
        @(posedge clk) cnt <= 16'h0000;
        #1 check(pout, 1'b0, "pwm fall");
        // center-aligned 8-bit PWM: level follows the masked compare, no latch
        write(CCC_MODE2_ADDR, 8'h42);
        @(posedge clk) {ca, nb, cmp, cnt} <= {1'b1, 2'h0, 16'h0040, 16'h1210};
        @(posedge clk) cnt <= 16'h3480;
        #1 check(pout, 1'b0, "center low");
        @(posedge clk) cnt <= 16'h0001;
        #1 check(pout, 1'b1, "center high");
        // frequency output: toggles on a masked match
        write(CCC_MODE2_ADDR, 8'h46);
        p = pout;
        @(posedge clk) cnt <= 16'hab40;
        @(posedge clk) cnt <= 16'hab41;
        #1 check(pout, !p, "freq toggle");
        // mid-run reset brings registers, flag and pin back to rest
        @(posedge clk) rst_n <= 0;
        @(posedge clk) rst_n <= 1;
        #1 check(c1l, CCC_BYTE_RST, "reset low");
        check(flag, 1'b0, "reset flag");
        check(pout, 1'b0, "reset pin");
        read(CCC_MODE2_ADDR, CCC_MODE_RST);
        conclude();
    end
endmodule : testbench
